// ### hw/csp_pkg.sv
package csp_pkg;

    // =========================================================================
    // Widths
    localparam int ADDR_W  = 3;
    localparam int DATA_W  = 8;
    localparam int PORT_W  = 5;
    localparam int CNT_W   = 22;

    // =========================================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_PORT_DATA  = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_PORT_DIR   = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PORT_PINS  = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 3'h4;

    // =========================================================================
    // Field positions
    localparam int SLEEP_EN_BIT   = 0;
    localparam int SLEEP_MODE_BIT = 1;
    localparam int ST_CODE_LSB    = 0;
    localparam int ST_XTAL_BIT    = 2;
    localparam int ST_RCSEL_BIT   = 3;
    localparam int ST_LONG_BIT    = 4;
    localparam int LINE_THREE     = 3;
    localparam int LINE_FOUR      = 4;

    // =========================================================================
    // Reset values
    localparam logic [1:0]        SLEEP_CTRL_RST = 2'h0;
    localparam logic [PORT_W-1:0] PORT_DATA_RST  = 5'h00;
    localparam logic [PORT_W-1:0] PORT_DIR_RST   = 5'h00;
    localparam logic [DATA_W-1:0] RD_DATA_RST    = 8'h00;

    // =========================================================================
    // Status codes of the power state
    localparam logic [1:0] CODE_START = 2'h0;
    localparam logic [1:0] CODE_RUN   = 2'h1;
    localparam logic [1:0] CODE_IDLE  = 2'h2;
    localparam logic [1:0] CODE_PDOWN = 2'h3;

    // =========================================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int STARTUP_SHORT_MS  = 1;
    localparam int STARTUP_LONG_MS   = 16;
    localparam int STARTUP_RC_US     = 16;
    localparam int RESET_MIN_NS      = 50;
    localparam int STARTUP_SHORT_CYC = (STARTUP_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_LONG_CYC  = (STARTUP_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_RC_CYC    = (STARTUP_RC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_START,
        ST_RUN,
        ST_IDLE,
        ST_PDOWN
    } csp_state_t;

endpackage

// ### hw/csp_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module csp_pin_cell (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic avail_in,
    input  wire logic data_we_in,
    input  wire logic dir_we_in,
    input  wire logic wr_bit_in,
    input  wire logic pin_in,
    output logic      data_out,
    output logic      dir_out,
    output logic      pin_sync_out,
    output logic      pin_out,
    output logic      pin_oe_out,
    output logic      pullup_en_out
);
    import csp_pkg::*;

    logic data_q;
    logic dir_q;
    logic meta_q;
    logic sync_q;

    // =========================================================================
    // Port bit storage and pad control
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_q <= 1'b0;
            dir_q  <= 1'b0;
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            if (data_we_in) begin
                data_q <= wr_bit_in;
            end
            if (dir_we_in) begin
                dir_q <= wr_bit_in;
            end
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    // Flops clear at once under reset, so the pad floats with no clock
    assign pin_oe_out    = dir_q & avail_in;
    assign pullup_en_out = ~dir_q & data_q & avail_in;
    assign pin_out       = data_q;
    assign data_out      = data_q;
    assign dir_out       = dir_q;
    assign pin_sync_out  = sync_q & avail_in;

endmodule // csp_pin_cell

`default_nettype wire

// ### hw/csp_ctrl.sv
// How it works
// - Idle halts core, peripherals keep running
// - Power-down stops oscillator, keeps registers, wakes
// - Crystal variant fuse picks 1 or 16 ms
// - Amplifier only on crystal variant, RC or external clock otherwise
// - Line three is I/O only with RC
// - Line four I/O only on RC-capable variant
// - Crystal variant port is three bits wide
// - Per-bit pull-up selectable on input pins
// - Any reset floats all port pins
// - Reset pin low over 50 ns resets
// - RC fuse zero selects internal RC clock on the non-crystal variant
`timescale 1ns/1ps
`default_nettype none

module csp_ctrl #(
    parameter logic [csp_pkg::CNT_W-1:0] SHORT_CYC = csp_pkg::CNT_W'(csp_pkg::STARTUP_SHORT_CYC),
    parameter logic [csp_pkg::CNT_W-1:0] LONG_CYC  = csp_pkg::CNT_W'(csp_pkg::STARTUP_LONG_CYC)
) (
    input  wire logic                         clk_in,
    input  wire logic                         nrst_in,
    input  wire logic                         variant_xtal_in,
    input  wire logic                         startup_long_fuse_in,
    input  wire logic                         internal_rc_select_fuse_in,
    input  wire logic                         wake_irq_in,
    input  wire logic                         sleep_instr_in,
    input  wire logic [csp_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic [csp_pkg::DATA_W-1:0]   wr_data_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    input  wire logic [csp_pkg::PORT_W-1:0]   port_pin_in,
    output logic      [csp_pkg::DATA_W-1:0]   rd_data_out,
    output logic      [csp_pkg::PORT_W-1:0]   port_pin_out,
    output logic      [csp_pkg::PORT_W-1:0]   port_pin_oe_out,
    output logic      [csp_pkg::PORT_W-1:0]   port_pullup_en_out,
    output logic                              core_exec_en_out,
    output logic                              periph_run_out,
    output logic                              osc_amp_en_out,
    output logic                              rc_osc_en_out,
    output logic                              ext_clk_sel_out
);
    import csp_pkg::*;

    localparam logic [CNT_W-1:0] RC_CYC = CNT_W'(STARTUP_RC_CYC);
    localparam logic [CNT_W-1:0] ONE    = 22'h00_0001;

    // =========================================================================
    // Synchronisers for straps, fuses and the wake line
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {wake_irq_in, internal_rc_select_fuse_in, startup_long_fuse_in, variant_xtal_in};
            sync2_q <= sync1_q;
        end
    end

    wire xtal_q   = sync2_q[0];
    wire long_q   = sync2_q[1];
    wire rcfuse_q = sync2_q[2];
    wire wake_q   = sync2_q[3];

    // =========================================================================
    // Clock source and pin availability
    wire rc_sel = ~xtal_q & ~rcfuse_q;
    wire [PORT_W-1:0] avail = {~xtal_q, rc_sel, 3'b111};

    wire [CNT_W-1:0] target = xtal_q ? (long_q ? LONG_CYC : SHORT_CYC)
                                     : RC_CYC;

    // =========================================================================
    // Register decode
    wire wr_sleep = wr_in & (addr_in == OFS_SLEEP_CTRL);
    wire wr_data  = wr_in & (addr_in == OFS_PORT_DATA);
    wire wr_dir   = wr_in & (addr_in == OFS_PORT_DIR);

    logic [1:0] sleep_ctrl_q;
    wire sleep_en   = sleep_ctrl_q[SLEEP_EN_BIT];
    wire sleep_pdwn = sleep_ctrl_q[SLEEP_MODE_BIT];

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleep_ctrl_q <= SLEEP_CTRL_RST;
        end else if (wr_sleep) begin
            sleep_ctrl_q <= wr_data_in[1:0];
        end
    end

    // =========================================================================
    // Port bits
    logic [PORT_W-1:0] data_bits;
    logic [PORT_W-1:0] dir_bits;
    logic [PORT_W-1:0] pin_bits;

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            csp_pin_cell u_cell (
                .clk_in        (clk_in),
                .nrst_in       (nrst_in),
                .avail_in      (avail[gi]),
                .data_we_in    (wr_data),
                .dir_we_in     (wr_dir),
                .wr_bit_in     (wr_data_in[gi]),
                .pin_in        (port_pin_in[gi]),
                .data_out      (data_bits[gi]),
                .dir_out       (dir_bits[gi]),
                .pin_sync_out  (pin_bits[gi]),
                .pin_out       (port_pin_out[gi]),
                .pin_oe_out    (port_pin_oe_out[gi]),
                .pullup_en_out (port_pullup_en_out[gi])
            );
        end
    endgenerate

    // =========================================================================
    // Power state machine
    csp_state_t       state_q;
    csp_state_t       state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    wire delay_done = (cnt_q >= target - ONE);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_START: begin
                cnt_d = cnt_q + ONE;
                if (delay_done) begin
                    state_d = ST_RUN;
                    cnt_d   = '0;
                end
            end
            ST_RUN: begin
                if (sleep_instr_in && sleep_en) begin
                    state_d = sleep_pdwn ? ST_PDOWN : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wake_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_PDOWN: begin
                if (wake_q) begin
                    state_d = ST_START;
                    cnt_d   = '0;
                end
            end
            default: begin
                state_d = ST_START;
                cnt_d   = '0;
            end
        endcase
    end

    // Pin low resets everything with no clock needed
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_START;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // =========================================================================
    // Registered clock and run controls
    wire run_d   = (state_d == ST_RUN);
    wire perip_d = (state_d == ST_RUN) || (state_d == ST_IDLE);
    wire osc_d   = (state_d != ST_PDOWN);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_exec_en_out <= 1'b0;
            periph_run_out   <= 1'b0;
            osc_amp_en_out   <= 1'b0;
            rc_osc_en_out    <= 1'b0;
            ext_clk_sel_out  <= 1'b0;
        end else begin
            core_exec_en_out <= run_d;
            periph_run_out   <= perip_d;
            osc_amp_en_out   <= osc_d & xtal_q;
            rc_osc_en_out    <= osc_d & rc_sel;
            ext_clk_sel_out  <= ~xtal_q & ~rc_sel;
        end
    end

    // =========================================================================
    // Read path
    logic [1:0] st_code;

    always_comb begin
        case (state_q)
            ST_START: st_code = CODE_START;
            ST_RUN:   st_code = CODE_RUN;
            ST_IDLE:  st_code = CODE_IDLE;
            ST_PDOWN: st_code = CODE_PDOWN;
            default:  st_code = CODE_START;
        endcase
    end

    wire [DATA_W-1:0] status_word = {3'b000, long_q, rc_sel, xtal_q, st_code};
    wire [DATA_W-1:0] rd_mux =
        (addr_in == OFS_SLEEP_CTRL) ? {6'b00_0000, sleep_ctrl_q} :
        (addr_in == OFS_PORT_DATA)  ? {3'b000, data_bits & avail} :
        (addr_in == OFS_PORT_DIR)   ? {3'b000, dir_bits & avail} :
        (addr_in == OFS_PORT_PINS)  ? {3'b000, pin_bits} :
        (addr_in == OFS_STATUS)     ? status_word :
                                      RD_DATA_RST;

    // Data shows only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= RD_DATA_RST;
        end else begin
            rd_data_out <= rd_in ? rd_mux : RD_DATA_RST;
        end
    end

    // =========================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    idle_core_hold_a: assert property (
        (state_q == ST_IDLE) |-> (!core_exec_en_out && periph_run_out)
    ) else $error("idle must halt core and keep peripherals");

    pdown_osc_stop_a: assert property (
        (state_q == ST_PDOWN) |-> (!osc_amp_en_out && !rc_osc_en_out && !periph_run_out)
    ) else $error("power-down must stop oscillator and peripherals");

    pdown_keep_regs_a: assert property (
        (state_q == ST_PDOWN) |=> $stable(sleep_ctrl_q) && $stable(data_bits) && $stable(dir_bits)
    ) else $error("power-down lost register contents");

    // Checked at release, since the target settles two cycles after reset
    startup_target_a: assert property (
        (state_q == ST_START && state_d == ST_RUN && xtal_q) |-> (cnt_q == (long_q ? LONG_CYC : SHORT_CYC) - ONE)
    ) else $error("wrong start-up delay selected");

    amp_variant_a: assert property (
        (!xtal_q |=> !osc_amp_en_out) and (xtal_q |=> !rc_osc_en_out)
    ) else $error("oscillator source does not match variant");

    line_three_a: assert property (
        !rc_sel |-> (!port_pin_oe_out[LINE_THREE] && !port_pullup_en_out[LINE_THREE])
    ) else $error("line three driven without internal clock");

    line_four_a: assert property (
        xtal_q |-> (!port_pin_oe_out[LINE_FOUR] && !port_pullup_en_out[LINE_FOUR])
    ) else $error("line four driven on crystal variant");

    crystal_width_a: assert property (
        (xtal_q && rd_in && addr_in == OFS_PORT_PINS) |=> (rd_data_out[7:3] == 5'b0_0000)
    ) else $error("crystal variant port wider than three bits");

    pullup_select_a: assert property (
        port_pullup_en_out == (~dir_bits & data_bits & avail)
    ) else $error("pull-up enable mismatch");

    // Antecedent holds nrst_in so the release edge starts no attempt
    rc_fuse_sel_a: assert property (
        (nrst_in && !xtal_q && !rcfuse_q && state_d != ST_PDOWN) |=> rc_osc_en_out
    ) else $error("programmed fuse did not select internal oscillator");

    startup_release_a: assert property (
        (state_q == ST_START && delay_done) |=> (state_q == ST_RUN && core_exec_en_out)
    ) else $error("core not released after start-up delay");

    startup_hold_a: assert property (
        (state_q == ST_START) |-> !core_exec_en_out
    ) else $error("core ran during start-up delay");

    read_timing_a: assert property (
        !$past(rd_in) |-> (rd_data_out == RD_DATA_RST)
    ) else $error("read data outside its cycle");

    // Reset checks watch the pin itself, so they stay live while it is low
    reset_float_a: assert property (disable iff (1'b0)
        !nrst_in |-> (port_pin_oe_out == '0 && port_pullup_en_out == '0)
    ) else $error("port pins driven during reset");

    reset_state_a: assert property (disable iff (1'b0)
        !nrst_in |-> (state_q == ST_START && cnt_q == '0 && !core_exec_en_out && sleep_ctrl_q == SLEEP_CTRL_RST)
    ) else $error("reset pin did not reset the block");

    sleep_refused_a: assert property (
        (state_q == ST_RUN && sleep_instr_in && !sleep_en) |=> (state_q == ST_RUN && core_exec_en_out)
    ) else $error("sleep taken while disabled");

    idle_entry_a: assert property (
        (state_q == ST_RUN && sleep_instr_in && sleep_en && !sleep_pdwn) |=> (state_q == ST_IDLE && periph_run_out)
    ) else $error("sleep did not enter idle");

    idle_wake_a: assert property (
        (state_q == ST_IDLE && wake_q) |=> (state_q == ST_RUN && core_exec_en_out)
    ) else $error("idle did not wake to run");

    pdown_entry_a: assert property (
        (state_q == ST_RUN && sleep_instr_in && sleep_en && sleep_pdwn) |=> (state_q == ST_PDOWN && !osc_amp_en_out)
    ) else $error("sleep did not enter power-down");

    pdown_hold_a: assert property (
        (state_q == ST_PDOWN && !wake_q) |=> (state_q == ST_PDOWN && !core_exec_en_out)
    ) else $error("power-down left without wake");

    pdown_wake_a: assert property (
        (state_q == ST_PDOWN && wake_q) |=> (state_q == ST_START && cnt_q == '0 && !core_exec_en_out)
    ) else $error("power-down wake skipped start-up");

    startup_count_a: assert property (
        (nrst_in && state_q == ST_START && !delay_done) |=> (state_q == ST_START && cnt_q == $past(cnt_q) + ONE)
    ) else $error("start-up counter skipped");

    ext_clock_a: assert property (
        (!xtal_q && rcfuse_q) |=> (ext_clk_sel_out && !rc_osc_en_out)
    ) else $error("unprogrammed fuse did not select external clock");

    crystal_port_a: assert property (
        xtal_q |-> (port_pin_oe_out[LINE_FOUR:LINE_THREE] == 2'h0 &&
                    port_pullup_en_out[LINE_FOUR:LINE_THREE] == 2'h0)
    ) else $error("crystal variant drives oscillator pins");

    pullup_input_a: assert property (
        (port_pullup_en_out & port_pin_oe_out) == '0
    ) else $error("pull-up enabled on a driven pin");

    line_three_rc_a: assert property (
        rc_sel |-> (port_pin_oe_out[LINE_THREE] == dir_bits[LINE_THREE])
    ) else $error("line three not free with internal clock");

    line_four_rc_a: assert property (
        !xtal_q |-> (port_pin_oe_out[LINE_FOUR] == dir_bits[LINE_FOUR])
    ) else $error("line four not free on RC variant");

endmodule // csp_ctrl

`default_nettype wire

// ### tb/csp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module csp_pad_model (
    input  wire logic                       clk_in,
    input  wire logic [csp_pkg::PORT_W-1:0] pin_out_in,
    input  wire logic [csp_pkg::PORT_W-1:0] pin_oe_in,
    input  wire logic [csp_pkg::PORT_W-1:0] pullup_in,
    input  wire logic [csp_pkg::PORT_W-1:0] ext_en_in,
    input  wire logic [csp_pkg::PORT_W-1:0] ext_val_in,
    output logic      [csp_pkg::PORT_W-1:0] pad_out
);
    import csp_pkg::*;
    // =========================================================================
    // Pad resolution
    logic [PORT_W-1:0] float_q = 5'h0a;
    // Undriven pads wander so a stale value never passes
    always @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pin_oe_in[i]) begin
                pad_out[i] = pin_out_in[i];
            end else if (ext_en_in[i]) begin
                pad_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                pad_out[i] = 1'b1;
            end else begin
                pad_out[i] = float_q[i];
            end
        end
    end
endmodule // csp_pad_model
`default_nettype wire

// ### tb/tb_clock_start_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_clock_start_power_mode_control;
    import csp_pkg::*;
    localparam int SHORT = 20;
    localparam int LONG  = 40;
    logic              clk_in = 0, nrst_in = 0, xtal = 0, long_f = 0, rc_f = 0;
    logic              wake = 0, sleep_i = 0, wr = 0, rd = 0, rd_pend = 0;
    logic [2:0]        addr = '0;
    logic [7:0]        wdata = '0, rdata;
    logic [4:0]        pad, pin_o, oe, pu, ext_en = '0, ext_val = '0, avail, d;
    logic              core, periph, amp, rco, extc, rcsel;
    logic [7:0]        exp_q[$];
    logic [2:0]        cfgs[4] = '{3'b101, 3'b111, 3'b000, 3'b001};
    int                num_errors = 0, n_tests = 0, tgt;

    always #2 clk_in = ~clk_in;

    csp_ctrl #(.SHORT_CYC(22'(SHORT)), .LONG_CYC(22'(LONG))) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .variant_xtal_in(xtal), .startup_long_fuse_in(long_f),
        .internal_rc_select_fuse_in(rc_f), .wake_irq_in(wake), .sleep_instr_in(sleep_i),
        .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .port_pin_in(pad),
        .rd_data_out(rdata), .port_pin_out(pin_o), .port_pin_oe_out(oe), .port_pullup_en_out(pu),
        .core_exec_en_out(core), .periph_run_out(periph), .osc_amp_en_out(amp),
        .rc_osc_en_out(rco), .ext_clk_sel_out(extc));

    csp_pad_model u_pads (
        .clk_in(clk_in), .pin_out_in(pin_o), .pin_oe_in(oe), .pullup_in(pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pad));

    // =========================================================================
    // Compare and report
    task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_lvl(got, exp);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Read data stands one cycle only, so pop exactly then
    always @(posedge clk_in) begin
        if (rd_pend) begin
            cmp_rd(rdata, exp_q.pop_front());
        end
        rd_pend <= rd;
    end

    // =========================================================================
    // Bus and sequencing tasks
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
    endtask
    task automatic pulse_sleep();
        @(posedge clk_in);
        sleep_i <= 1'b1;
        @(posedge clk_in);
        sleep_i <= 1'b0;
        #1;
    endtask
    // Bounded wait; sync stages add a few cycles of slack
    task automatic wait_run(input int lo, input int hi);
        int cnt;
        cnt = 0;
        while (core !== 1'b1 && cnt <= hi) begin
            @(posedge clk_in);
            cnt++;
        end
        cmp_lvl(8'(cnt >= lo && cnt <= hi), 8'h01);
    endtask
    function automatic logic [7:0] status(input logic [1:0] code);
        return {3'b000, long_f, rcsel, xtal, code};
    endfunction

    // =========================================================================
    // Main sequence
    initial begin
        void'($urandom(32'h821b5bdd));
        foreach (cfgs[k]) begin
            @(posedge clk_in);
            {xtal, long_f, rc_f} <= cfgs[k];
            nrst_in <= 1'b0;
            #2;
            cmp_lvl(8'(pu | oe), 8'h00);
            repeat (16) @(posedge clk_in);
            cmp_lvl(8'({pu, core}), 8'h00);
            nrst_in <= 1'b1;
            rcsel = !xtal && !rc_f;
            avail = xtal ? 5'h07 : (rcsel ? 5'h1f : 5'h17);
            tgt = xtal ? (long_f ? LONG : SHORT) : STARTUP_RC_CYC;
            wait_run(tgt, tgt + 6);
            #1;
            cmp_lvl(8'(amp), 8'(xtal));
            cmp_lvl(8'(rco), 8'(rcsel));
            cmp_lvl(8'(extc), 8'(!xtal && rc_f));
            rd_reg(OFS_STATUS, status(CODE_RUN));
            // Port lines driven with random data
            d = 5'($urandom);
            wr_reg(OFS_PORT_DIR, 8'h1f);
            wr_reg(OFS_PORT_DATA, {3'b000, d});
            #1;
            cmp_lvl(8'(oe), 8'(avail));
            cmp_lvl(8'(pin_o & avail), 8'(d & avail));
            rd_reg(OFS_PORT_DATA, {3'b000, d & avail});
            rd_reg(OFS_PORT_DIR, {3'b000, avail});
            // Inputs with pull-ups, some pulled low outside
            wr_reg(OFS_PORT_DIR, 8'h00);
            wr_reg(OFS_PORT_DATA, 8'h1f);
            #1;
            cmp_lvl(8'(pu), 8'(avail));
            @(posedge clk_in);
            ext_val <= 5'($urandom);
            ext_en <= 5'h1f;
            repeat (4) @(posedge clk_in);
            rd_reg(OFS_PORT_PINS, {3'b000, ext_val & avail});
            ext_en <= 5'h00;
            wr_reg(3'h7, 8'hff);
            rd_reg(3'h7, 8'h00);
            // Sleep refused while disabled, then idle
            pulse_sleep();
            cmp_lvl(8'(core), 8'h01);
            wr_reg(OFS_SLEEP_CTRL, 8'h01);
            pulse_sleep();
            cmp_lvl(8'({core, periph}), 8'h01);
            rd_reg(OFS_STATUS, status(CODE_IDLE));
            wake <= 1'b1;
            wait_run(1, 6);
            wake <= 1'b0;
            // Power-down keeps registers, wakes through start-up
            wr_reg(OFS_SLEEP_CTRL, 8'h03);
            pulse_sleep();
            cmp_lvl(8'({core, periph, amp, rco}), 8'h00);
            @(posedge clk_in);
            wake <= 1'b1;
            repeat (4) @(posedge clk_in);
            wake <= 1'b0;
            wait_run(tgt - 4, tgt + 8);
            rd_reg(OFS_PORT_DATA, {3'b000, avail});
            rd_reg(OFS_SLEEP_CTRL, 8'h03);
            $display("test %0d done", k);
        end
        repeat (3) @(posedge clk_in);
        final_report();
    end

    // Four configs, two start-ups each, worst case about 17k cycles
    initial begin
        #(4 * 60000);
        num_errors++;
        final_report();
    end
endmodule // tb_clock_start_power_mode_control
`default_nettype wire
